// ===== hdl/mbs_regs.svh
// Purpose: Register map, field positions, reset values and timing constants of the brake sequencer
// Assumes: AHB-Lite slave with one aligned 32-bit word per register
// Notes: Hold times in ms, PWM frequency in Hz, PWM duty in percent
// Functional notes
// - Auto mode: brake engaged except operation enabled
// - Submode bit 2 set selects auto
// - Submode bit 2 clear: brake follows output bit 0
// - Entry: current on, hold 3, release, hold 4, travel
// - Exit: standstill, hold 1, engage, hold 2, current off
// - Switched-on brake output is PWM
// - PWM frequency in Hz, above 2000 refused
// - Duty percent 2 to 100, frequency independent
// - Duty 100 holds output steadily on
// - Override enable and value force brake level
`ifndef MBS_REGS_SVH
`define MBS_REGS_SVH

// Register byte offsets
`define MBS_A_SUBMODE 8'h00
`define MBS_A_DOUT 8'h04
`define MBS_A_OVR 8'h08
`define MBS_A_HOLD1 8'h0C
`define MBS_A_HOLD4 8'h18
`define MBS_A_FREQ 8'h1C
`define MBS_A_DUTY 8'h20
`define MBS_A_STATUS 8'h24
`define MBS_A_STEP 8'h04

// Field positions
`define MBS_SUB_AUTO_BIT 2
`define MBS_DOUT_BRAKE_BIT 0
`define MBS_OVR_EN_BIT 0
`define MBS_OVR_VAL_BIT 1

// Reset values and limits
`define MBS_FREQ_RST 16'h03E8
`define MBS_FREQ_MIN 16'h0001
`define MBS_FREQ_MAX 16'h07D0
`define MBS_DUTY_RST 7'h64
`define MBS_DUTY_MIN 7'h02
`define MBS_DUTY_FULL 7'h64
`define MBS_PCT_SCALE 32'h0000_0064
`define MBS_HOLD_RST 16'h0000

// Timing
`define MBS_CLK_PERIOD_NS 32'h0000_0032
`define MBS_NS_PER_S 32'h3B9A_CA00
`define MBS_HOLD_UNIT_NS 32'h000F_4240
`define MBS_CLK_HZ (`MBS_NS_PER_S / `MBS_CLK_PERIOD_NS)
`define MBS_MS_CYCLES (`MBS_HOLD_UNIT_NS / `MBS_CLK_PERIOD_NS)

`endif

// ===== hdl/mbs_pkg.sv
// Purpose: Types shared by the brake sequencer
// Assumes: Nothing
// Notes: State order is free, no codes given
package mbs_pkg;
  // Brake sequencer states
  typedef enum logic [2:0] {
    S_OFF, S_HOLD3, S_HOLD4, S_RUN, S_STOP, S_HOLD1, S_HOLD2
  } mbs_state_t;
endpackage

// ===== hdl/mbs_brake_pwm.sv
// Purpose: Brake PWM generator with frequency in Hz and duty in percent
// Assumes: freqHz within 1..2000 and dutyPct within 2..100, checked by the caller
// Notes: Phase accumulator keeps the period independent of the duty setting
`timescale 1ns/1ns
`include "mbs_regs.svh"
module mbs_brake_pwm #(
  parameter logic [31:0] CLK_HZ = `MBS_CLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Settings
  input wire logic [15:0] freqHz,
  input wire logic [6:0] dutyPct,
  // Output
  output logic pwmLevel
);
  logic [31:0] acc; // Phase, 0 up to CLK_HZ-1
  wire [31:0] sum = acc + {16'h0000, freqHz};
  wire wrap = sum >= CLK_HZ;
  wire [31:0] next_acc = wrap ? sum - CLK_HZ : sum;
  // Compare phase against duty share of the full scale
  wire [31:0] phaseScaled = 32'(acc * `MBS_PCT_SCALE);
  wire [31:0] dutyScaled = 32'({25'h000_0000, dutyPct} * CLK_HZ);
  wire next_level = (dutyPct == `MBS_DUTY_FULL) || (phaseScaled < dutyScaled);

  // Phase and output flops
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= 32'h0000_0000;
      pwmLevel <= 1'b0;
    end else begin
      acc <= next_acc;
      pwmLevel <= next_level;
    end
  end
endmodule

// ===== hdl/mbs_brake_seq.sv
// Purpose: Holding-brake sequencer with timed steps and brake PWM, AHB-Lite registers
// Assumes: opEnableReq and motorStandstill come from drive logic on clk
// Notes: Zero wait states, response always OKAY
//
// The address map and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "mbs_regs.svh"
module mbs_brake_seq
  import mbs_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MBS_MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Drive state machine
  input wire logic opEnableReq,
  input wire logic motorStandstill,
  output logic motorCurrentOn,
  output logic haltRequest,
  output logic travelEnable,
  // Brake pin
  output logic brakePin
);
  localparam int TW = $clog2(MS_CYCLES + 1);

  // Address phase capture
  logic aValid; // Data phase of an accepted word transfer
  logic aWrite;
  logic [7:0] aAddr;
  logic aHigh; // Upper address bits nonzero, unmapped

  // Software registers
  logic autoMode; // Submode auto bit
  logic doutBrake; // Digital output brake bit
  logic ovrEn;
  logic ovrVal;
  logic [15:0] holdTime [4]; // Hold times 1..4 in ms
  logic [15:0] pwmFreq;
  logic [6:0] pwmDuty;

  // Sequencer
  mbs_state_t state;
  mbs_state_t next_state;
  logic [15:0] holdLeft; // Whole ms still to wait
  logic [TW-1:0] tickCnt; // Cycles within the current ms
  logic brakePinPre;
  logic pwmLevel;
  logic autoRelease; // Brake lifted by the automatic sequence
  logic brakeOn; // Brake output switched on, before PWM and override

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Capture address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      aValid <= 1'b0;
      aWrite <= 1'b0;
      aAddr <= 8'h00;
      aHigh <= 1'b0;
    end else begin
      aValid <= hsel && htrans[1] && hready && (hsize == 3'b010);
      aWrite <= hwrite;
      aAddr <= haddr[7:0];
      aHigh <= |haddr[31:8];
    end
  end

  // Write decode
  wire wrSel = aValid && aWrite && !aHigh;
  wire wrSubmode = wrSel && (aAddr == `MBS_A_SUBMODE);
  wire wrDout = wrSel && (aAddr == `MBS_A_DOUT);
  wire wrOvr = wrSel && (aAddr == `MBS_A_OVR);
  wire wrFreq = wrSel && (aAddr == `MBS_A_FREQ);
  wire wrDuty = wrSel && (aAddr == `MBS_A_DUTY);
  // Out of range values leave the old setting in place
  wire freqOk = (hwdata[31:16] == 16'h0000) && (hwdata[15:0] >= `MBS_FREQ_MIN)
    && (hwdata[15:0] <= `MBS_FREQ_MAX);
  wire dutyOk = (hwdata[31:7] == 25'h000_0000) && (hwdata[6:0] >= `MBS_DUTY_MIN)
    && (hwdata[6:0] <= `MBS_DUTY_FULL);

  // Control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      autoMode <= 1'b0;
      doutBrake <= 1'b0;
      ovrEn <= 1'b0;
      ovrVal <= 1'b0;
      pwmFreq <= `MBS_FREQ_RST;
      pwmDuty <= `MBS_DUTY_RST;
    end else begin
      if (wrSubmode) autoMode <= hwdata[`MBS_SUB_AUTO_BIT];
      if (wrDout) doutBrake <= hwdata[`MBS_DOUT_BRAKE_BIT];
      if (wrOvr) begin
        ovrEn <= hwdata[`MBS_OVR_EN_BIT];
        ovrVal <= hwdata[`MBS_OVR_VAL_BIT];
      end
      if (wrFreq && freqOk) pwmFreq <= hwdata[15:0];
      if (wrDuty && dutyOk) pwmDuty <= hwdata[6:0];
    end
  end

  // Hold time registers, one word each
  generate
    for (genvar i = 0; i < 4; i++) begin : g_hold
      wire wrHold = wrSel && (aAddr == 8'(`MBS_A_HOLD1 + i * `MBS_A_STEP));
      always_ff @(posedge clk) begin
        if (rst) holdTime[i] <= `MBS_HOLD_RST;
        else if (wrHold) holdTime[i] <= hwdata[15:0];
      end
    end
  endgenerate

  // Read mux, driven from register flops during the data phase
  wire inHold = (aAddr >= `MBS_A_HOLD1) && (aAddr <= `MBS_A_HOLD4);
  wire [7:0] holdOff = aAddr - `MBS_A_HOLD1;
  wire [31:0] statusWord = {22'h00_0000, 3'(state), brakePin, pwmLevel, travelEnable,
    haltRequest, motorCurrentOn, brakeOn, autoRelease};
  assign hrdata = (!aValid || aWrite || aHigh) ? 32'h0000_0000 :
    (aAddr == `MBS_A_SUBMODE) ? 32'(autoMode) << `MBS_SUB_AUTO_BIT :
    (aAddr == `MBS_A_DOUT) ? 32'(doutBrake) << `MBS_DOUT_BRAKE_BIT :
    (aAddr == `MBS_A_OVR) ? {30'h0000_0000, ovrVal, ovrEn} :
    inHold ? {16'h0000, holdTime[holdOff[3:2]]} :
    (aAddr == `MBS_A_FREQ) ? {16'h0000, pwmFreq} :
    (aAddr == `MBS_A_DUTY) ? {25'h000_0000, pwmDuty} :
    (aAddr == `MBS_A_STATUS) ? statusWord : 32'h0000_0000;

  // Millisecond timing of the hold steps
  wire msTick = tickCnt == TW'(MS_CYCLES - 1);
  wire holdDone = holdLeft == 16'h0000; // Zero hold passes at once
  wire enter = next_state != state;
  wire [15:0] loadVal = (next_state == S_HOLD1) ? holdTime[0] :
    (next_state == S_HOLD2) ? holdTime[1] :
    (next_state == S_HOLD3) ? holdTime[2] :
    (next_state == S_HOLD4) ? holdTime[3] : 16'h0000;

  // Next step of the power sequence
  always_comb begin
    next_state = state;
    case (state)
      S_OFF: if (opEnableReq) next_state = S_HOLD3; // Current on
      S_HOLD3: begin
        if (!opEnableReq) next_state = S_OFF; // Brake never released
        else if (holdDone) next_state = S_HOLD4; // Release
      end
      S_HOLD4: begin
        if (!opEnableReq) next_state = S_STOP;
        else if (holdDone) next_state = S_RUN; // Travel allowed
      end
      S_RUN: if (!opEnableReq) next_state = S_STOP;
      S_STOP: if (motorStandstill) next_state = S_HOLD1;
      S_HOLD1: if (holdDone) next_state = S_HOLD2; // Engage
      S_HOLD2: if (holdDone) next_state = S_OFF; // Current off
      default: next_state = S_OFF;
    endcase
  end

  // State and hold counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_OFF;
      holdLeft <= 16'h0000;
      tickCnt <= '0;
    end else begin
      state <= next_state;
      if (enter) begin
        holdLeft <= loadVal;
        tickCnt <= '0;
      end else if (!holdDone) begin
        if (msTick) begin
          holdLeft <= holdLeft - 16'h0001;
          tickCnt <= '0;
        end else begin
          tickCnt <= tickCnt + TW'(1);
        end
      end
    end
  end

  // Step outputs
  assign autoRelease = (state == S_HOLD4) || (state == S_RUN) || (state == S_STOP)
    || (state == S_HOLD1);
  assign motorCurrentOn = state != S_OFF;
  assign travelEnable = state == S_RUN;
  assign haltRequest = (state == S_STOP) || (state == S_HOLD1) || (state == S_HOLD2);
  // Brake switched on: auto sequence or manual output bit
  assign brakeOn = autoMode ? autoRelease : doutBrake;

  // Brake PWM source
  mbs_brake_pwm #(.CLK_HZ(`MBS_CLK_HZ)) u_pwm (
    .clk(clk),
    .rst(rst),
    .freqHz(pwmFreq),
    .dutyPct(pwmDuty),
    .pwmLevel(pwmLevel)
  );

  // Override wins, otherwise PWM gated by the switched-on brake
  assign brakePinPre = ovrEn ? ovrVal : (brakeOn && pwmLevel);
  always_ff @(posedge clk) begin
    if (rst) brakePin <= 1'b0;
    else brakePin <= brakePinPre;
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sReleaseStep;
    state == S_HOLD3 ##1 state == S_HOLD4;
  endsequence
  sequence sEngageStep;
    state == S_HOLD1 ##1 state == S_HOLD2;
  endsequence

  a_auto_engaged: assert property (autoMode && !ovrEn && !autoRelease |=> !brakePin)
    else $error("brake released outside operation enabled");
  a_auto_select: assert property (autoMode && state == S_RUN |-> brakeOn)
    else $error("auto mode did not release in run");
  a_manual_brake: assert property (!autoMode |-> brakeOn == doutBrake)
    else $error("manual brake not following output bit");
  a_entry_order: assert property (sReleaseStep |-> motorCurrentOn && !travelEnable
    && (!autoMode || brakeOn))
    else $error("release step out of order");
  a_travel_after: assert property ($rose(travelEnable) |-> $past(state) == S_HOLD4)
    else $error("travel enabled before hold 4");
  a_exit_order: assert property (sEngageStep |-> motorCurrentOn && !autoRelease)
    else $error("engage step out of order");
  a_current_off: assert property ($fell(motorCurrentOn) |-> $past(state) == S_HOLD2
    || $past(state) == S_HOLD3)
    else $error("current off before brake engaged");
  a_pwm_output: assert property (!ovrEn && brakeOn |=> brakePin == $past(pwmLevel))
    else $error("brake pin not following PWM");
  a_freq_refuse: assert property (wrFreq && !freqOk |=> $stable(pwmFreq))
    else $error("illegal frequency accepted");
  a_duty_range: assert property (pwmDuty >= `MBS_DUTY_MIN && pwmDuty <= `MBS_DUTY_FULL)
    else $error("duty out of range");
  a_full_duty: assert property (!ovrEn && brakeOn && pwmDuty == `MBS_DUTY_FULL
    && $stable(pwmDuty) |=> brakePin)
    else $error("full duty not steady on");
  a_override_pin: assert property (ovrEn |=> brakePin == $past(ovrVal))
    else $error("override level not applied");
  a_zero_hold: assert property (enter && next_state == S_HOLD2 && holdTime[1] == 16'h0000
    |=> state == S_HOLD2 ##1 state == S_OFF)
    else $error("zero hold time waited");
endmodule

// ===== dv/mbs_brake_model.sv
// Purpose: Holding brake on the motor, seen from the brake pin
// Assumes: brakePin high energises the coil and lifts the brake
// Notes: The spring closes the brake only after the coil stays dead a while
`timescale 1ns/1ns
module mbs_brake_model #(
  parameter int RELAX = 8
) (
  // Clock
  input wire logic clk,
  // Brake pin
  input wire logic brakePin,
  // Mechanical state
  output logic released
);
  // Cycles the coil has been dead, starts closed
  int lowCnt = RELAX;
  // PWM gaps shorter than RELAX do not let the brake fall in
  always_ff @(posedge clk) begin
    if (brakePin === 1'b1) begin
      lowCnt <= 0;
    end else if (lowCnt < RELAX) begin
      lowCnt <= lowCnt + 1;
    end
  end
  // Lifted while the coil was recently powered
  assign released = (lowCnt < RELAX);
endmodule

// ===== dv/motor_brake_sequencer_pwm_tb_top.sv
// Purpose: Self-checking bench for the brake sequencer
// Assumes: MS_CYCLES of 4 makes one ms four clocks
// Notes: Ranges allow for the registered pin stages
`timescale 1ns/1ns
`include "mbs_regs.svh"
module motor_brake_sequencer_pwm_tb_top;
  // Bench state
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, opEnableReq = 0, motorStandstill = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  wire hreadyout, hresp, motorCurrentOn, haltRequest, travelEnable, brakePin, released;
  wire [31:0] hrdata;
  int nMismatch = 0, samplesChecked = 0;
  localparam logic [31:0] AH2 = 32'h0000_0010, AH3 = 32'h0000_0014;
  // Clock at 20 MHz
  always #25 clk = ~clk;
  // Device under test
  mbs_brake_seq #(.MS_CYCLES(4)) uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .opEnableReq(opEnableReq),
    .motorStandstill(motorStandstill), .motorCurrentOn(motorCurrentOn),
    .haltRequest(haltRequest), .travelEnable(travelEnable), .brakePin(brakePin));
  // Brake on the far side
  mbs_brake_model brake (.clk(clk), .brakePin(brakePin), .released(released));
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One AHB single transfer, address phase then data phase
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  // Cycles with the pin high over a span
  task hiCount(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      c += (brakePin === 1'b1);
    end
  endtask
  // Select a drive-side output by number
  function logic sig(input int k);
    case (k)
      0: return motorCurrentOn;
      1: return brakePin;
      2: return travelEnable;
      default: return haltRequest;
    endcase
  endfunction
  // Bounded wait for a level, returns cycles spent
  task waitLvl(input int k, input logic v, output int n);
    n = 0;
    while (sig(k) !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask
  // Reset values and unmapped space
  task testReset;
    rdc(`MBS_A_FREQ, 32'h0000_03E8);
    rdc(`MBS_A_DUTY, 32'h0000_0064);
    rdc(`MBS_A_SUBMODE, 32'h0000_0000);
    wr(32'h0000_0100, 32'h0000_0005);
    rdc(32'h0000_0100, 32'h0000_0000);
    chk(brakePin, 1'b0);
  endtask
  // Limits of frequency and duty
  task testLimits;
    wr(`MBS_A_FREQ, 32'h0000_07D1);
    chk({hreadyout, hresp}, 2'b10);
    rdc(`MBS_A_FREQ, 32'h0000_03E8);
    wr(`MBS_A_FREQ, 32'h0000_07D0);
    rdc(`MBS_A_FREQ, 32'h0000_07D0);
    wr(`MBS_A_DUTY, 32'h0000_0001);
    rdc(`MBS_A_DUTY, 32'h0000_0064);
    wr(`MBS_A_DUTY, 32'h0000_0065);
    rdc(`MBS_A_DUTY, 32'h0000_0064);
    wr(`MBS_A_DUTY, 32'h0000_0002);
    rdc(`MBS_A_DUTY, 32'h0000_0002);
    wr(`MBS_A_DUTY, 32'h0000_0064);
  endtask
  // Manual brake bit and override
  task testManual;
    int c;
    wr(`MBS_A_DOUT, 32'h0000_0001);
    repeat (4) @(posedge clk);
    hiCount(50, c);
    chk(c, 50);
    wr(`MBS_A_OVR, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk(brakePin, 1'b0);
    wr(`MBS_A_OVR, 32'h0000_0003);
    wr(`MBS_A_DOUT, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk(brakePin, 1'b1);
    wr(`MBS_A_OVR, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk(brakePin, 1'b0);
  endtask
  // PWM duty over whole periods at two frequencies
  task testPwm;
    int c;
    wr(`MBS_A_DUTY, 32'h0000_0019);
    wr(`MBS_A_DOUT, 32'h0000_0001);
    hiCount(10000, c);
    chk(c >= 2498 && c <= 2502, 1'b1);
    wr(`MBS_A_FREQ, 32'h0000_03E8);
    hiCount(20000, c);
    chk(c >= 4998 && c <= 5002, 1'b1);
    wr(`MBS_A_DUTY, 32'h0000_0064);
  endtask
  // Automatic entry and exit steps
  task testAuto;
    int n;
    wr(`MBS_A_SUBMODE, 32'h0000_0004);
    wr(AH3, 32'h0000_0002);
    wr(`MBS_A_HOLD4, 32'h0000_0001);
    wr(`MBS_A_HOLD1, 32'h0000_0001);
    wr(AH2, 32'h0000_0002);
    repeat (4) @(posedge clk);
    chk(brakePin, 1'b0);
    opEnableReq <= 1;
    waitLvl(0, 1'b1, n);
    chk(n <= 2 && brakePin === 1'b0, 1'b1);
    waitLvl(1, 1'b1, n);
    chk(n >= 8 && n <= 11 && travelEnable === 1'b0, 1'b1);
    waitLvl(2, 1'b1, n);
    chk(n >= 1 && n <= 4, 1'b1);
    rdc(`MBS_A_STATUS, 32'h0000_01F7);
    opEnableReq <= 0;
    waitLvl(3, 1'b1, n);
    chk(n >= 1 && n <= 3, 1'b1);
    repeat (10) @(posedge clk);
    chk({travelEnable, brakePin, released}, 3'h3);
    motorStandstill <= 1;
    waitLvl(1, 1'b0, n);
    chk(n >= 5 && n <= 9 && motorCurrentOn === 1'b1, 1'b1);
    waitLvl(0, 1'b0, n);
    chk(n >= 5 && n <= 9, 1'b1);
    chk(released, 1'b0);
    wr(AH3, 32'h0000_0000);
    wr(`MBS_A_HOLD4, 32'h0000_0000);
    wr(AH2, 32'h0000_0000);
    opEnableReq <= 1;
    waitLvl(2, 1'b1, n);
    chk(n <= 6, 1'b1);
    opEnableReq <= 0;
    waitLvl(0, 1'b0, n);
    chk(n >= 6 && n <= 10, 1'b1);
    motorStandstill <= 0;
  endtask
  // Verdict and end of run
  task test_done;
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    testReset;
    testLimits;
    testManual;
    testPwm;
    testAuto;
    test_done;
  end
  // Watchdog well beyond the expected run
  initial begin
    #4_000_000;
    nMismatch++;
    test_done;
  end
endmodule
